// ==== sdsb_pkg.sv ====
// constants and bundle types for the separate-port burst sram
package sdsb_pkg;
  localparam int ADDR_W      = 20;
  localparam int DATA_W      = 36;
  localparam int LANE_W      = 9;
  localparam int LANES       = 4;
  localparam int BURST_W     = 2 * DATA_W;
  localparam int LAT_LONG    = 2;
  localparam int LAT_SHORT   = 1;
  localparam int PIPE_W      = 2;
  localparam int RD_FIFO_DEP = 4;

  typedef struct packed {
    logic              k;
    logic              k_n;
    logic              pll_bypass_select_n;
    logic              read_port_select_n;
    logic              write_port_select_n;
    logic [LANES-1:0]  byte_write_select_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } sdsb_pins_t;

  localparam sdsb_pins_t PINS_IDLE = '{
    k: 1'b0, k_n: 1'b0, pll_bypass_select_n: 1'b1,
    read_port_select_n: 1'b1, write_port_select_n: 1'b1,
    byte_write_select_n: 4'hF, addr: 20'h0_0000, data: 36'h0_0000_0000};

  typedef struct packed {
    logic [DATA_W-1:0] first;
    logic [DATA_W-1:0] second;
  } sdsb_burst_t;
endpackage

// ==== sdsb_sram.sv ====
// separate-port ddr burst sram core with read data fifo
//
// Operation
// RL1 - read, write addresses on alternate rising edges
// RL2 - each location holds two 36-bit words
// RL3 - data moves on both clocks' rising edges
// RL4 - only rising edges of clocks are used
// RL5 - bypass select high: read latency two cycles
// RL6 - bypass select low: read latency one cycle
// RL7 - read and write ports run concurrently
// RL8 - valid flag marks phases carrying read data
// RL9 - echo clocks travel with read data
// RL10 - all synchronous inputs registered before use
// RL11 - read data driven from output registers
// RL12 - writes self-timed, no external write pulse
// RL13 - reads return most recently written data
// RL14 - separate select per port for depth
// RL15 - write select low starts write, else ignored
// RL16 - read address on k, write on k_n
// RL17 - byte selects gate 9-bit lanes
// RL18 - controller provides 20 address bits
// RL19 - read select low starts read, else ignored
// RL20 - first word precedes second word
`timescale 1ns/100ps
`default_nettype none

module sdsb_fifo #(
  parameter int WIDTH = 72,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [IW-1:0]    wr_ptr_reg;
  logic [IW-1:0]    wr_ptr_next;
  logic [IW-1:0]    rd_ptr_reg;
  logic [IW-1:0]    rd_ptr_next;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  function automatic logic [IW-1:0] ptr_inc(input logic [IW-1:0] p);
    ptr_inc = (p == IW'(DEPTH - 1)) ? '0 : IW'(p + 1'b1);
  endfunction

  assign in_ready_o  = (count_reg != CW'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data_i;
      wr_ptr_next          = ptr_inc(wr_ptr_reg);
    end
    if (pop) begin
      rd_ptr_next = ptr_inc(rd_ptr_reg);
    end
    if (push && !pop) begin
      count_next = CW'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_next = CW'(count_reg - 1'b1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end
endmodule

module sdsb_sram #(
  parameter int ADDR_W   = sdsb_pkg::ADDR_W,
  parameter int STORE_AW = 4,
  parameter int FIFO_DEP = sdsb_pkg::RD_FIFO_DEP
) (
  input  wire logic                        REF_CLK_I,
  input  wire logic                        RST_I,
  input  wire logic                        K_I,
  input  wire logic                        K_N_I,
  input  wire logic                        PLL_BYPASS_SELECT_N_I,
  input  wire logic                        READ_PORT_SELECT_N_I,
  input  wire logic                        WRITE_PORT_SELECT_N_I,
  input  wire logic [sdsb_pkg::LANES-1:0]  BYTE_WRITE_SELECT_N_I,
  input  wire logic [ADDR_W-1:0]           ADDR_I,
  input  wire logic [sdsb_pkg::DATA_W-1:0] D_I,
  output logic      [sdsb_pkg::DATA_W-1:0] Q_O,
  output logic                             OUTPUT_VALID_FLAG_O,
  output logic                             ECHO_CLOCK_O,
  output logic                             ECHO_CLOCK_N_O
);
  localparam int DEPTH = 1 << STORE_AW;

  sdsb_pkg::sdsb_pins_t pins_in;
  sdsb_pkg::sdsb_pins_t meta_reg;
  sdsb_pkg::sdsb_pins_t sync_reg;
  logic                 k_old_reg;
  logic                 kn_old_reg;
  logic                 k_rise;
  logic                 kn_rise;

  // inputs pass two flops, edges found from the second stage
  always_comb begin
    pins_in                     = sdsb_pkg::PINS_IDLE;
    pins_in.k                   = K_I;
    pins_in.k_n                 = K_N_I;
    pins_in.pll_bypass_select_n = PLL_BYPASS_SELECT_N_I;
    pins_in.read_port_select_n  = READ_PORT_SELECT_N_I;
    pins_in.write_port_select_n = WRITE_PORT_SELECT_N_I;
    pins_in.byte_write_select_n = BYTE_WRITE_SELECT_N_I;
    pins_in.addr                = sdsb_pkg::ADDR_W'(ADDR_I);
    pins_in.data                = D_I;
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      meta_reg   <= sdsb_pkg::PINS_IDLE;
      sync_reg   <= sdsb_pkg::PINS_IDLE;
      k_old_reg  <= 1'b0;
      kn_old_reg <= 1'b0;
    end else begin
      meta_reg   <= pins_in;           // see RL10
      sync_reg   <= meta_reg;
      k_old_reg  <= sync_reg.k;
      kn_old_reg <= sync_reg.k_n;
    end
  end

  assign k_rise  = sync_reg.k && !k_old_reg;     // see RL4
  assign kn_rise = sync_reg.k_n && !kn_old_reg;  // see RL4

  function automatic logic [sdsb_pkg::DATA_W-1:0] lane_merge(
    input logic [sdsb_pkg::DATA_W-1:0] old_w,
    input logic [sdsb_pkg::DATA_W-1:0] new_w,
    input logic [sdsb_pkg::LANES-1:0]  sel_n);
    lane_merge = old_w;
    for (int i = 0; i < sdsb_pkg::LANES; i++) begin
      if (!sel_n[i]) begin
        lane_merge[i*sdsb_pkg::LANE_W +: sdsb_pkg::LANE_W] =
          new_w[i*sdsb_pkg::LANE_W +: sdsb_pkg::LANE_W];  // see RL17
      end
    end
  endfunction

  // write port: select and first word on k, address and second word on k_n
  sdsb_pkg::sdsb_burst_t       array_reg [DEPTH];
  sdsb_pkg::sdsb_burst_t       array_next [DEPTH];
  logic                        wr_pend_reg;
  logic                        wr_pend_next;
  logic [sdsb_pkg::DATA_W-1:0] wr_first_reg;
  logic [sdsb_pkg::DATA_W-1:0] wr_first_next;
  logic [sdsb_pkg::LANES-1:0]  wr_sel_reg;
  logic [sdsb_pkg::LANES-1:0]  wr_sel_next;
  logic [STORE_AW-1:0]         wr_idx;
  logic [STORE_AW-1:0]         rd_idx;

  assign wr_idx = sync_reg.addr[STORE_AW-1:0];
  assign rd_idx = sync_reg.addr[STORE_AW-1:0];

  always_comb begin
    array_next    = array_reg;
    wr_pend_next  = wr_pend_reg;
    wr_first_next = wr_first_reg;
    wr_sel_next   = wr_sel_reg;
    if (k_rise) begin
      wr_pend_next  = !sync_reg.write_port_select_n;  // see RL15 RL14
      wr_first_next = sync_reg.data;                  // see RL3
      wr_sel_next   = sync_reg.byte_write_select_n;
    end
    if (kn_rise && wr_pend_reg) begin
      // self-timed array update on the k_n edge that carries the last word
      array_next[wr_idx].first  = lane_merge(array_reg[wr_idx].first,
                                             wr_first_reg, wr_sel_reg);  // see RL12 RL16
      array_next[wr_idx].second = lane_merge(array_reg[wr_idx].second,
                                             sync_reg.data,
                                             sync_reg.byte_write_select_n);  // see RL2 RL3
      wr_pend_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < DEPTH; i++) begin
        array_reg[i] <= '0;
      end
      wr_pend_reg  <= 1'b0;
      wr_first_reg <= '0;
      wr_sel_reg   <= 4'hF;
    end else begin
      array_reg    <= array_next;
      wr_pend_reg  <= wr_pend_next;
      wr_first_reg <= wr_first_next;
      wr_sel_reg   <= wr_sel_next;
    end
  end

  // read port: request on k, burst queued then released after the latency
  sdsb_pkg::sdsb_burst_t rd_in;
  sdsb_pkg::sdsb_burst_t rd_out;
  logic                  rd_req;
  logic                  rd_in_ready;
  logic                  rd_out_valid;
  logic                  rd_pop;
  logic                  rd_issue;
  logic                  lat_long;
  logic [sdsb_pkg::PIPE_W-1:0] pipe_reg;
  logic [sdsb_pkg::PIPE_W-1:0] pipe_next;

  // reads see the array after any completed write burst
  assign rd_in    = array_reg[rd_idx];                                 // see RL13
  assign rd_req   = k_rise && !sync_reg.read_port_select_n && rd_in_ready;  // see RL19 RL14 RL1
  assign lat_long = sync_reg.pll_bypass_select_n;
  assign rd_issue = k_rise && (lat_long ? pipe_reg[sdsb_pkg::LAT_LONG - 1]      // see RL5
                                        : pipe_reg[sdsb_pkg::LAT_SHORT - 1]);  // see RL6
  assign rd_pop   = rd_issue && rd_out_valid;

  sdsb_fifo #(
    .WIDTH (sdsb_pkg::BURST_W),
    .DEPTH (FIFO_DEP)
  ) u_rd_fifo (
    .clk_i       (REF_CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (rd_req),
    .in_ready_o  (rd_in_ready),
    .in_data_i   (rd_in),
    .out_valid_o (rd_out_valid),
    .out_ready_i (rd_pop),
    .out_data_o  (rd_out)
  );

  always_comb begin
    pipe_next = pipe_reg;
    if (k_rise) begin
      pipe_next = {pipe_reg[sdsb_pkg::PIPE_W-2:0], rd_req};  // see RL7
    end
  end

  // output phase sequencer
  logic [sdsb_pkg::DATA_W-1:0] q_reg;
  logic [sdsb_pkg::DATA_W-1:0] q_next;
  logic [sdsb_pkg::DATA_W-1:0] hold_reg;
  logic [sdsb_pkg::DATA_W-1:0] hold_next;
  logic                        vld_reg;
  logic                        vld_next;
  logic                        sec_reg;
  logic                        sec_next;
  logic                        echo_reg;
  logic                        echo_n_reg;

  always_comb begin
    q_next    = q_reg;
    hold_next = hold_reg;
    vld_next  = vld_reg;
    sec_next  = sec_reg;
    if (k_rise) begin
      if (rd_pop) begin
        q_next    = rd_out.first;   // see RL20
        hold_next = rd_out.second;
        vld_next  = 1'b1;           // see RL8
        sec_next  = 1'b1;
      end else begin
        vld_next = 1'b0;            // see RL8
      end
    end else if (kn_rise && sec_reg) begin
      q_next   = hold_reg;          // see RL20 RL3
      sec_next = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pipe_reg   <= '0;
      q_reg      <= '0;
      hold_reg   <= '0;
      vld_reg    <= 1'b0;
      sec_reg    <= 1'b0;
      echo_reg   <= 1'b0;
      echo_n_reg <= 1'b0;
    end else begin
      pipe_reg   <= pipe_next;
      q_reg      <= q_next;
      hold_reg   <= hold_next;
      vld_reg    <= vld_next;
      sec_reg    <= sec_next;
      echo_reg   <= sync_reg.k;     // see RL9
      echo_n_reg <= sync_reg.k_n;   // see RL9
    end
  end

  assign Q_O                 = q_reg;  // see RL11
  assign OUTPUT_VALID_FLAG_O = vld_reg;
  assign ECHO_CLOCK_O        = echo_reg;
  assign ECHO_CLOCK_N_O      = echo_n_reg;
endmodule

`default_nettype wire

// ==== sdsb_sram_checker.sv ====
// port assertions for the burst sram, bound to its top
`timescale 1ns/100ps
`default_nettype none
module sdsb_sram_checker (
  input wire logic                        REF_CLK_I,
  input wire logic                        RST_I,
  input wire logic                        K_I,
  input wire logic                        K_N_I,
  input wire logic                        PLL_BYPASS_SELECT_N_I,
  input wire logic                        READ_PORT_SELECT_N_I,
  input wire logic [sdsb_pkg::DATA_W-1:0] Q_O,
  input wire logic                        OUTPUT_VALID_FLAG_O,
  input wire logic                        ECHO_CLOCK_O,
  input wire logic                        ECHO_CLOCK_N_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  a_echo_k_follow: assert property ($rose(K_I) |-> ##[1:5] $rose(ECHO_CLOCK_O))
    else $error("echo clock lost the link clock");
  a_echo_kn_follow: assert property ($rose(K_N_I) |-> ##[1:5] $rose(ECHO_CLOCK_N_O))
    else $error("inverted echo clock lost the link clock");
  a_valid_rise_k: assert property ($rose(OUTPUT_VALID_FLAG_O) |-> K_I)
    else $error("valid rose outside the first word phase");
  a_valid_fall_k: assert property ($fell(OUTPUT_VALID_FLAG_O) |-> K_I)
    else $error("valid fell outside a main clock phase");
  a_valid_whole_burst: assert property ($rose(OUTPUT_VALID_FLAG_O) |->
    OUTPUT_VALID_FLAG_O[*8] ##1 OUTPUT_VALID_FLAG_O[*8]) else $error("valid shorter than a burst");
  a_q_holds_phase: assert property (
    (K_I && $past(K_I, 7)) || (K_N_I && $past(K_N_I, 7)) |-> $stable(Q_O))
    else $error("read data moved late in a phase");
  a_long_latency: assert property (
    $rose(K_I) && !READ_PORT_SELECT_N_I && PLL_BYPASS_SELECT_N_I
    |-> ##[34:38] OUTPUT_VALID_FLAG_O) else $error("two cycle read data missing");
  a_short_latency: assert property (
    $rose(K_I) && !READ_PORT_SELECT_N_I && !PLL_BYPASS_SELECT_N_I
    |-> ##[18:22] OUTPUT_VALID_FLAG_O) else $error("one cycle read data missing");
  a_valid_has_read: assert property ($rose(OUTPUT_VALID_FLAG_O) |->
    (PLL_BYPASS_SELECT_N_I ? !$past(READ_PORT_SELECT_N_I, 36)
                           : !$past(READ_PORT_SELECT_N_I, 20)))
    else $error("valid without read");
  c_long_read: cover property ($rose(OUTPUT_VALID_FLAG_O) && PLL_BYPASS_SELECT_N_I);
  c_short_read: cover property ($rose(OUTPUT_VALID_FLAG_O) && !PLL_BYPASS_SELECT_N_I);
  c_back_to_back: cover property (OUTPUT_VALID_FLAG_O[*8] ##1 OUTPUT_VALID_FLAG_O[*8]
    ##17 OUTPUT_VALID_FLAG_O);
endmodule
bind sdsb_sram sdsb_sram_checker u_sdsb_sram_checker (.REF_CLK_I(REF_CLK_I), .RST_I(RST_I),
  .K_I(K_I), .K_N_I(K_N_I), .PLL_BYPASS_SELECT_N_I(PLL_BYPASS_SELECT_N_I),
  .READ_PORT_SELECT_N_I(READ_PORT_SELECT_N_I), .Q_O(Q_O),
  .OUTPUT_VALID_FLAG_O(OUTPUT_VALID_FLAG_O),
  .ECHO_CLOCK_O(ECHO_CLOCK_O), .ECHO_CLOCK_N_O(ECHO_CLOCK_N_O));
`default_nettype wire

// ==== sdsb_ctrl_model.sv ====
// controller model: link clocks and slotted pins
`timescale 1ns/100ps
`default_nettype none
module sdsb_ctrl_model (
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  run_i,
  input  wire logic                  rd_n_i,
  input  wire logic                  wr_n_i,
  input  wire logic [19:0]           ra_i,
  input  wire logic [19:0]           wa_i,
  input  wire sdsb_pkg::sdsb_burst_t w_i,
  input  wire logic [7:0]            lane_sel_n_i,
  output var sdsb_pkg::sdsb_pins_t   pins_o,
  output logic [3:0]                 cnt_o
);
  sdsb_pkg::sdsb_pins_t pins_reg, pins_next;
  logic [3:0]           cnt_reg, cnt_next;
  always_comb begin
    cnt_next = cnt_reg + {3'h0, run_i};
    pins_next = pins_reg;
    pins_next.k = run_i && !cnt_next[3];
    pins_next.k_n = run_i && cnt_next[3];
    if (run_i && cnt_reg == 4'hB) begin
      pins_next.read_port_select_n = rd_n_i;
      pins_next.write_port_select_n = wr_n_i;
      pins_next.addr = ra_i;
      pins_next.data = wr_n_i ? ~pins_reg.data : w_i.first;
      pins_next.byte_write_select_n = lane_sel_n_i[3:0];
    end
    if (run_i && cnt_reg == 4'h3) begin
      pins_next.addr = wa_i;
      pins_next.data = wr_n_i ? ~pins_reg.data : w_i.second;
      pins_next.byte_write_select_n = lane_sel_n_i[7:4];
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pins_reg <= sdsb_pkg::PINS_IDLE;
      cnt_reg <= 4'hC;
    end else begin
      pins_reg <= pins_next;
      cnt_reg <= cnt_next;
    end
  end
  assign pins_o = pins_reg;
  assign cnt_o = cnt_reg;
endmodule
`default_nettype wire

// ==== sdsb_sram_tb.sv ====
// self-checking testbench for the burst sram
`timescale 1ns/100ps
`default_nettype none
module sdsb_sram_tb;
  logic                  clk, rst, run, rd_n, wr_n, byp, qv, v1;
  logic [3:0]            cnt;
  logic [7:0]            per, lane_n;
  logic [19:0]           ra, wa;
  logic [35:0]           q, q1;
  logic                  expv [256];
  sdsb_pkg::sdsb_burst_t w, mem [16], expd [256];
  sdsb_pkg::sdsb_pins_t  pins;
  int                    error_cnt, check_count;
  sdsb_sram u_sdsb_sram (.REF_CLK_I(clk), .RST_I(rst), .K_I(pins.k), .K_N_I(pins.k_n),
    .PLL_BYPASS_SELECT_N_I(byp), .READ_PORT_SELECT_N_I(pins.read_port_select_n),
    .WRITE_PORT_SELECT_N_I(pins.write_port_select_n),
    .BYTE_WRITE_SELECT_N_I(pins.byte_write_select_n), .ADDR_I(pins.addr), .D_I(pins.data),
    .Q_O(q), .OUTPUT_VALID_FLAG_O(qv), .ECHO_CLOCK_O(), .ECHO_CLOCK_N_O());
  sdsb_ctrl_model u_sdsb_ctrl_model (.clk_i(clk), .rst_i(rst), .run_i(run), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .ra_i(ra), .wa_i(wa), .w_i(w), .lane_sel_n_i(lane_n), .pins_o(pins),
    .cnt_o(cnt));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // word one sampled late in the main phase, word two late in the inverted phase
  always @(posedge clk) begin
    if (cnt === 4'h7) begin
      q1 = q;
      v1 = qv;
    end
    if (cnt === 4'hF) begin
      check_count++;
      if (v1 !== expv[per] || qv !== expv[per] ||
          (expv[per] && {q1, q} !== expd[per])) begin
        error_cnt++;
        $display("[ERR] %0t period %0d read burst wrong", $time, per);
      end
      expv[per] = 1'b0;
      per = per + 8'h01;
    end
  end
  // one link period: read slot r/a, write slot wn/b with burst d and lane selects s
  task automatic slot(input logic r, input logic [3:0] a, input logic wn, input logic [3:0] b,
                      input sdsb_pkg::sdsb_burst_t d, input logic [7:0] s);
    logic [7:0] k;
    do @(posedge clk); while (cnt !== 4'hA);
    rd_n <= r;
    wr_n <= wn;
    ra <= {16'h0000, a};
    wa <= {16'h0000, b};
    w <= d;
    lane_n <= s;
    k = per + (byp ? 8'h03 : 8'h02);
    if (!r) begin
      expv[k] = 1'b1;
      expd[k] = mem[a];
    end
    for (int i = 0; i < 4; i++) begin
      if (!wn && !s[i]) mem[b].first[9*i +: 9] = d.first[9*i +: 9];
      if (!wn && !s[4+i]) mem[b].second[9*i +: 9] = d.second[9*i +: 9];
    end
  endtask
  task automatic flush;
    repeat (4) slot(1'b1, 4'h0, 1'b1, 4'h0, '0, 8'hFF);
  endtask
  task automatic t_lat2;
    slot(1'b1, 4'h0, 1'b0, 4'h3, '{36'h1_2345_6789, 36'h9_8765_4321}, 8'h00);
    slot(1'b0, 4'h3, 1'b1, 4'h0, '0, 8'hFF);
    flush;
    $display("t_lat2 done");
  endtask
  task automatic t_concurrent;
    slot(1'b0, 4'h3, 1'b0, 4'h3, '{36'hA_AAAA_0001, 36'h5_5555_0002}, 8'h00);
    slot(1'b0, 4'h3, 1'b0, 4'h5, '{36'h0_F0F0_1234, 36'h0_0F0F_4321}, 8'h00);
    slot(1'b0, 4'h5, 1'b1, 4'h0, '0, 8'hFF);
    flush;
    $display("t_concurrent done");
  endtask
  task automatic t_lanes;
    slot(1'b1, 4'h0, 1'b0, 4'h5, '{36'hF_FFFF_FFFF, 36'hF_FFFF_FFFF}, 8'hA6);
    slot(1'b0, 4'h5, 1'b1, 4'h0, '0, 8'hFF);
    flush;
    $display("t_lanes done");
  endtask
  task automatic t_deselect;
    slot(1'b1, 4'h5, 1'b1, 4'h5, '{36'h1_1111_1111, 36'h2_2222_2222}, 8'h00);
    slot(1'b0, 4'h5, 1'b1, 4'h0, '0, 8'hFF);
    flush;
    $display("t_deselect done");
  endtask
  task automatic t_lat1;
    byp <= 1'b0;
    flush;
    slot(1'b0, 4'h5, 1'b0, 4'h7, '{36'h3_C3C3_0007, 36'h7_0707_3C3C}, 8'h00);
    slot(1'b0, 4'h7, 1'b1, 4'h0, '0, 8'hFF);
    flush;
    $display("t_lat1 done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    run = 1'b0;
    byp = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    ra = '0;
    wa = '0;
    w = '0;
    lane_n = 8'hFF;
    per = 8'h00;
    error_cnt = 0;
    check_count = 0;
    for (int i = 0; i < 256; i++) begin
      expv[i] = 1'b0;
      mem[i % 16] = '0;
    end
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    run <= 1'b1;
    t_lat2;
    t_concurrent;
    t_lanes;
    t_deselect;
    t_lat1;
    give_verdict;
  end
  // about 35 link periods are needed; allow several times that
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict;
  end
endmodule
`default_nettype wire
